// *** verilog/iop_exc_pkg.sv ***
package iop_exc_pkg;
  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int OP_W = 7;
  localparam int CH_W = 6;
  localparam int NUM_CH = 32;
  localparam int SP_W = 4;
  localparam int FN_W = 4;
  localparam int PADDR_W = 8;

  // ************************************************************
  // Opcodes
  // ************************************************************
  localparam logic [OP_W-1:0] OP_DISABLE = 7'h02;
  localparam logic [OP_W-1:0] OP_ENABLE = 7'h03;
  localparam logic [OP_W-1:0] OP_IO_LO = 7'h20;
  localparam logic [OP_W-1:0] OP_IO_HI = 7'h23;
  localparam logic [OP_W-1:0] OP_BR_LO = 7'h38;
  localparam logic [OP_W-1:0] OP_BR_HI = 7'h5F;
  localparam logic [OP_W-1:0] OP_RJ_LO = 7'h5C;
  localparam logic [OP_W-1:0] OP_RJ_HI = 7'h5F;
  localparam logic [OP_W-1:0] OP_CHD_LO = 7'h60;
  localparam logic [OP_W-1:0] OP_CHD_HI = 7'h6F;
  localparam logic [OP_W-1:0] OP_CHB_LO = 7'h70;
  localparam logic [OP_W-1:0] OP_CHB_HI = 7'h7F;

  // ************************************************************
  // Channel functions and exit stack
  // ************************************************************
  localparam logic [FN_W-1:0] FN_CLR_EN = 4'h6;
  localparam logic [FN_W-1:0] FN_SET_EN = 4'h7;
  localparam logic [FN_W-1:0] FN_SP_LOAD = 4'hC;
  localparam logic [FN_W-1:0] FN_SP_WRITE = 4'hD;
  localparam logic [CH_W-1:0] EXS_CHANNEL = 6'h02;
  localparam logic [SP_W-1:0] SP_RESET = 4'h0;
  localparam logic [SP_W-1:0] SP_BOUNDARY = 4'hE;
  localparam logic [ADDR_W-1:0] RJ_RET_OFS = 16'h0002;
  localparam logic [ADDR_W-1:0] INT_RET_OFS = 16'h0001;
  localparam logic [ADDR_W-1:0] INT_SKIP_OFS = 16'h0002;
  localparam int CHEN_DELAY_CP = 3;

  // ************************************************************
  // Interrupt vectors
  // ************************************************************
  localparam logic [1:0] VEC_NONE = 2'h0;
  localparam logic [1:0] VEC_PFR = 2'h1;
  localparam logic [1:0] VEC_BOUND = 2'h2;
  localparam logic [1:0] VEC_CHAN = 2'h3;

  // ************************************************************
  // APB register map and fields
  // ************************************************************
  localparam logic [PADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [PADDR_W-1:0] REG_CHEN = 8'h04;
  localparam logic [PADDR_W-1:0] REG_PEND = 8'h08;
  localparam logic [PADDR_W-1:0] REG_STACK = 8'h0C;
  localparam int ST_IE = 0;
  localparam int ST_EN_PEND = 1;
  localparam int ST_SYS_INT = 2;
  localparam int ST_SP_LSB = 4;
  localparam int PEND_PFR = 0;
  localparam int PEND_BOUND = 1;
  localparam logic [NUM_CH-1:0] CHEN_RESET = 32'h0000_0000;

  function automatic logic in_range(input logic [OP_W-1:0] op, input logic [OP_W-1:0] lo,
                                    input logic [OP_W-1:0] hi);
    in_range = (op >= lo) && (op <= hi);
  endfunction

  function automatic logic holds_enable(input logic [OP_W-1:0] op);
    holds_enable = in_range(op, OP_IO_LO, OP_IO_HI) || in_range(op, OP_BR_LO, OP_BR_HI);
  endfunction
endpackage

// *** verilog/exit_stack_mem.sv ***
`timescale 1ns/1ps
module exit_stack_mem #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// *** verilog/iop_interrupt_exit_stack_ctrl.sv ***
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Opcodes 134-137 return jump to operand d plus k on carry/accumulator test.
// - Opcodes 140-157 send functions 0-17 to channel named by d field.
// - Opcodes 160-177 send functions 0-17 to channel held in operand B.
// - Accepted interrupt pushes the exit stack; pointer 13 becomes 14.
// - Return jump at pointer 13 then fetch interrupt fill locations 14 and 15.
// - Boundary and fetch interrupts both pend; fetch request has priority.
// - Stack overflow wraps pointer to 0, overwriting location 0.
// - Enable opcode 003 takes effect at next nonbranch non-I/O instruction.
// - Opcodes 40-43 and 70-137 never complete a pending enable.
// - Interrupt after redundant enable enters disabled; first plain instruction re-enables.
// - Interrupt during disable opcode 002 may skip the following instruction.
// - Channel command 6/7 changes system interrupt contribution three clocks later.
module iop_interrupt_exit_stack_ctrl
  import iop_exc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue_valid,
  input wire logic [OP_W-1:0] issue_op,
  input wire logic [8:0] issue_d,
  input wire logic [ADDR_W-1:0] issue_k,
  input wire logic [ADDR_W-1:0] issue_p,
  input wire logic carry_nz,
  input wire logic [ADDR_W-1:0] acc_value,
  input wire logic [ADDR_W-1:0] opd_value,
  input wire logic [ADDR_W-1:0] opb_value,
  input wire logic [NUM_CH-1:0] chan_irq,
  input wire logic program_fetch_request_interrupt,
  output logic jump_valid,
  output logic [ADDR_W-1:0] jump_target,
  output logic chan_fn_valid,
  output logic [CH_W-1:0] chan_num,
  output logic [FN_W-1:0] chan_fn,
  output logic int_take,
  output logic [1:0] int_vector,
  output logic [ADDR_W-1:0] int_ret_addr,
  output logic sys_int
);
  // ************************************************************
  // State
  // ************************************************************
  logic sys_ie_r;
  logic en_pend_r;
  logic pfr_pend_r;
  logic bound_pend_r;
  logic [SP_W-1:0] sp_r;
  logic [NUM_CH-1:0] chen_r;
  logic [CHEN_DELAY_CP-2:0] dly_v_r;
  logic [CHEN_DELAY_CP-2:0] dly_set_r;
  logic [CH_W-1:0] dly_ch_r [0:CHEN_DELAY_CP-2];
  logic [ADDR_W-1:0] stack_top;

  // ************************************************************
  // Instruction decode
  // ************************************************************
  logic is_rj, rj_cond, rj_taken;
  logic is_chd, is_chb, is_ch;
  logic [CH_W-1:0] ch_sel;
  logic [FN_W-1:0] fn_sel;
  logic op_dis, op_en, op_plain;
  logic any_int, int_take_c;
  logic [1:0] vec_c;
  logic exs_fn, sp_load, sp_write, push;
  logic [SP_W-1:0] sp_nxt;
  logic chen_cmd;

  assign is_rj = issue_valid && in_range(issue_op, OP_RJ_LO, OP_RJ_HI);
  always_comb begin
    unique case (issue_op[1:0])
      2'h0: rj_cond = !carry_nz;
      2'h1: rj_cond = carry_nz;
      2'h2: rj_cond = (acc_value == '0);
      2'h3: rj_cond = (acc_value != '0);
    endcase
  end
  assign rj_taken = is_rj && rj_cond;
  assign is_chd = issue_valid && in_range(issue_op, OP_CHD_LO, OP_CHD_HI);
  assign is_chb = issue_valid && in_range(issue_op, OP_CHB_LO, OP_CHB_HI);
  assign is_ch = is_chd || is_chb;
  assign ch_sel = is_chb ? opb_value[CH_W-1:0] : issue_d[CH_W-1:0];
  assign fn_sel = issue_op[FN_W-1:0];
  assign op_dis = issue_valid && (issue_op == OP_DISABLE);
  assign op_en = issue_valid && (issue_op == OP_ENABLE);
  assign op_plain = issue_valid && !holds_enable(issue_op) && !op_en && !op_dis;

  // ************************************************************
  // Interrupt arbitration
  // ************************************************************
  assign sys_int = |(chan_irq & chen_r);
  assign any_int = pfr_pend_r || bound_pend_r || sys_int;
  assign int_take_c = issue_valid && sys_ie_r && any_int && !rj_taken;
  always_comb begin
    if (pfr_pend_r) begin
      vec_c = VEC_PFR;
    end else if (bound_pend_r) begin
      vec_c = VEC_BOUND;
    end else if (sys_int) begin
      vec_c = VEC_CHAN;
    end else begin
      vec_c = VEC_NONE;
    end
  end

  // ************************************************************
  // Exit stack
  // ************************************************************
  assign exs_fn = is_ch && (ch_sel == EXS_CHANNEL);
  assign sp_load = exs_fn && (fn_sel == FN_SP_LOAD);
  assign sp_write = exs_fn && (fn_sel == FN_SP_WRITE);
  assign push = rj_taken || int_take_c;
  assign sp_nxt = sp_r + 4'h1;

  logic mem_we;
  logic [SP_W-1:0] mem_waddr;
  logic [ADDR_W-1:0] mem_wdata;
  logic [ADDR_W-1:0] int_ret_c;
  assign int_ret_c = issue_p + (op_dis ? INT_SKIP_OFS : INT_RET_OFS);
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = sp_r;
    mem_wdata = acc_value;
    if (rj_taken) begin
      mem_we = 1'b1;
      mem_waddr = sp_nxt;
      mem_wdata = issue_p + RJ_RET_OFS;
    end else if (int_take_c) begin
      mem_we = 1'b1;
      mem_waddr = sp_nxt;
      mem_wdata = int_ret_c;
    end else if (sp_write) begin
      mem_we = 1'b1;
    end
  end

  exit_stack_mem #(
    .AW(SP_W),
    .DW(ADDR_W)
  ) u_stack (
    .clk(pclk),
    .rst_n(presetn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(sp_r),
    .rdata(stack_top)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= SP_RESET;
    end else if (push) begin
      sp_r <= sp_nxt;
    end else if (sp_load) begin
      sp_r <= acc_value[SP_W-1:0];
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  logic apb_wr, apb_rd, addr_ok;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign addr_ok = (paddr == REG_STATUS) || (paddr == REG_CHEN) || (paddr == REG_PEND) || (paddr == REG_STACK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        REG_STATUS: prdata <= 32'(sys_ie_r) | (32'(en_pend_r) << ST_EN_PEND) | (32'(sys_int) << ST_SYS_INT)
                              | (32'(sp_r) << ST_SP_LSB);
        REG_CHEN: prdata <= 32'(chen_r);
        REG_PEND: prdata <= 32'(pfr_pend_r) | (32'(bound_pend_r) << PEND_BOUND);
        REG_STACK: prdata <= 32'(stack_top);
        default: prdata <= '0;
      endcase
    end
  end

  // ************************************************************
  // Pending interrupts, set wins over clear
  // ************************************************************
  logic clr_pfr, clr_bound;
  assign clr_pfr = apb_wr && (paddr == REG_PEND) && pwdata[PEND_PFR];
  assign clr_bound = apb_wr && (paddr == REG_PEND) && pwdata[PEND_BOUND];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfr_pend_r <= 1'b0;
    end else if (program_fetch_request_interrupt) begin
      pfr_pend_r <= 1'b1;
    end else if (clr_pfr) begin
      pfr_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bound_pend_r <= 1'b0;
    end else if (push && (sp_nxt >= SP_BOUNDARY)) begin
      bound_pend_r <= 1'b1;
    end else if (clr_bound) begin
      bound_pend_r <= 1'b0;
    end
  end

  // ************************************************************
  // System interrupt enable
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_ie_r <= 1'b0;
      en_pend_r <= 1'b0;
    end else if (op_dis) begin
      sys_ie_r <= 1'b0;
      en_pend_r <= 1'b0;
    end else if (int_take_c) begin
      sys_ie_r <= 1'b0;
    end else if (op_en) begin
      en_pend_r <= 1'b1;
    end else if (op_plain && en_pend_r) begin
      sys_ie_r <= 1'b1;
      en_pend_r <= 1'b0;
    end
  end

  // ************************************************************
  // Channel enables with command delay
  // ************************************************************
  assign chen_cmd = is_ch && ((fn_sel == FN_CLR_EN) || (fn_sel == FN_SET_EN));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_v_r <= '0;
      dly_set_r <= '0;
      for (int i = 0; i < CHEN_DELAY_CP - 1; i++) begin
        dly_ch_r[i] <= '0;
      end
    end else begin
      dly_v_r[0] <= chen_cmd;
      dly_set_r[0] <= (fn_sel == FN_SET_EN);
      dly_ch_r[0] <= ch_sel;
      for (int i = 1; i < CHEN_DELAY_CP - 1; i++) begin
        dly_v_r[i] <= dly_v_r[i-1];
        dly_set_r[i] <= dly_set_r[i-1];
        dly_ch_r[i] <= dly_ch_r[i-1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chen_r <= CHEN_RESET;
    end else if (dly_v_r[CHEN_DELAY_CP-2]) begin
      chen_r[dly_ch_r[CHEN_DELAY_CP-2][4:0]] <= dly_set_r[CHEN_DELAY_CP-2];
    end else if (apb_wr && (paddr == REG_CHEN)) begin
      chen_r <= pwdata[NUM_CH-1:0];
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jump_valid <= 1'b0;
      jump_target <= '0;
    end else begin
      jump_valid <= rj_taken;
      if (rj_taken) begin
        jump_target <= opd_value + issue_k;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_fn_valid <= 1'b0;
      chan_num <= '0;
      chan_fn <= '0;
    end else begin
      chan_fn_valid <= is_ch;
      if (is_ch) begin
        chan_num <= ch_sel;
        chan_fn <= fn_sel;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_take <= 1'b0;
      int_vector <= VEC_NONE;
      int_ret_addr <= '0;
    end else begin
      int_take <= int_take_c;
      if (int_take_c) begin
        int_vector <= vec_c;
        int_ret_addr <= int_ret_c;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RJ_TARGET: assert property (rj_taken |=> jump_valid && jump_target == $past(opd_value) + $past(issue_k))
    else $error("return jump target wrong");
  AST_RJ_NOT_TAKEN: assert property (is_rj && !rj_cond && !int_take_c |=> !jump_valid && $stable(sp_r))
    else $error("untaken return jump acted");
  AST_CHD: assert property (is_chd |=> chan_fn_valid && chan_num == $past(issue_d[CH_W-1:0])
                                       && chan_fn == $past(issue_op[FN_W-1:0]))
    else $error("d channel function wrong");
  AST_CHB: assert property (is_chb |=> chan_fn_valid && chan_num == $past(opb_value[CH_W-1:0]))
    else $error("B channel function wrong");
  AST_INT_PUSH: assert property (int_take_c |=> sp_r == $past(sp_r) + 4'h1 && int_take)
    else $error("interrupt push wrong");
  AST_RJ_13: assert property (rj_taken && sp_r == 4'hD |-> mem_we && mem_waddr == 4'hE)
    else $error("return jump at 13 misplaced");
  AST_PRIO: assert property (int_take_c && pfr_pend_r && bound_pend_r |=> int_vector == VEC_PFR)
    else $error("fetch request not first");
  AST_WRAP: assert property (push && sp_r == 4'hF |=> sp_r == 4'h0)
    else $error("stack did not wrap");
  AST_EN_DELAY: assert property (op_en && !sys_ie_r |=> !sys_ie_r && en_pend_r)
    else $error("enable took effect at once");
  AST_EN_HOLD: assert property (en_pend_r && !sys_ie_r && issue_valid && holds_enable(issue_op)
                                |=> !sys_ie_r)
    else $error("branch or I/O completed enable");
  AST_REENTRY: assert property (int_take_c && en_pend_r && !op_dis
                                |=> !sys_ie_r && en_pend_r)
    else $error("redundant enable entry wrong");
  AST_SKIP: assert property (int_take_c && op_dis |=> int_ret_addr == $past(issue_p) + INT_SKIP_OFS)
    else $error("disable skip address wrong");
  AST_CHEN_3CP: assert property (chen_cmd |-> ##3
                                 chen_r[$past(ch_sel[4:0], 3)] == ($past(fn_sel, 3) == FN_SET_EN))
    else $error("channel enable delay wrong");

  COV_RJ_13: cover property (rj_taken && sp_r == 4'hD ##[1:20] int_take_c);
  COV_REDUNDANT: cover property (sys_ie_r && op_en ##[1:10] int_take_c);
  COV_CHEN: cover property (chen_cmd ##3 sys_int);
endmodule

// *** testbench/prog_model.sv ***
`timescale 1ns/1ps
module prog_model
  import iop_exc_pkg::*;
(
  input wire logic pclk,
  output logic issue_valid,
  output logic [OP_W-1:0] issue_op,
  output logic [8:0] issue_d,
  output logic [ADDR_W-1:0] issue_k,
  output logic [ADDR_W-1:0] issue_p,
  output logic carry_nz,
  output logic [ADDR_W-1:0] acc_value,
  output logic [ADDR_W-1:0] opd_value,
  output logic [ADDR_W-1:0] opb_value,
  output logic [NUM_CH-1:0] chan_irq,
  output logic program_fetch_request_interrupt
);
  // ********************
  // Program and channels
  // ********************
  localparam logic [OP_W-1:0] PASS_OP = 7'h00;
  localparam int EXS_WAIT = 5;

  initial begin
    issue_valid = 1'b0;
    issue_op = 7'h00;
    issue_d = 9'h000;
    issue_k = 16'h0000;
    issue_p = 16'h0000;
    carry_nz = 1'b0;
    acc_value = 16'h0000;
    opd_value = 16'h0100;
    opb_value = 16'h0009;
    chan_irq = 32'h0000_0000;
    program_fetch_request_interrupt = 1'b0;
  end

  // One instruction, valid for one cycle
  task automatic issue(input logic [OP_W-1:0] op, input logic [8:0] d, input logic [ADDR_W-1:0] k,
                       input logic c, input logic [ADDR_W-1:0] a);
    @(posedge pclk);
    issue_valid <= 1'b1;
    issue_op <= op;
    issue_d <= d;
    issue_k <= k;
    issue_p <= issue_p + 16'h0001;
    carry_nz <= c;
    acc_value <= a;
    @(posedge pclk);
    issue_valid <= 1'b0;
  endtask

  // Channel interrupt levels and fetch request
  task automatic irq(input logic [NUM_CH-1:0] v, input logic f);
    @(posedge pclk);
    chan_irq <= v;
    program_fetch_request_interrupt <= f;
  endtask

  // Stack function, issued with interrupts off, then settle time
  task automatic exs(input logic [FN_W-1:0] fn, input logic [ADDR_W-1:0] a);
    issue(OP_CHD_LO + 7'(fn), 9'(EXS_CHANNEL), 16'h0000, 1'b0, a);
    for (int i = 0; i < EXS_WAIT; i++) begin
      issue(PASS_OP, 9'h000, 16'h0000, 1'b0, a);
    end
  endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import iop_exc_pkg::*;
;
  // ********************
  // Signals
  // ********************
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [PADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic issue_valid;
  logic [OP_W-1:0] issue_op;
  logic [8:0] issue_d;
  logic [ADDR_W-1:0] issue_k;
  logic [ADDR_W-1:0] issue_p;
  logic carry_nz;
  logic [ADDR_W-1:0] acc_value;
  logic [ADDR_W-1:0] opd_value;
  logic [ADDR_W-1:0] opb_value;
  logic [NUM_CH-1:0] chan_irq;
  logic program_fetch_request_interrupt;
  logic jump_valid;
  logic [ADDR_W-1:0] jump_target;
  logic chan_fn_valid;
  logic [CH_W-1:0] chan_num;
  logic [FN_W-1:0] chan_fn;
  logic int_take;
  logic [1:0] int_vector;
  logic [ADDR_W-1:0] int_ret_addr;
  logic sys_int;
  int n_fail;
  int checks;
  logic [DATA_W-1:0] rv;
  logic er;

  iop_interrupt_exit_stack_ctrl iop_interrupt_exit_stack_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .issue_valid(issue_valid),
    .issue_op(issue_op), .issue_d(issue_d), .issue_k(issue_k), .issue_p(issue_p), .carry_nz(carry_nz),
    .acc_value(acc_value), .opd_value(opd_value), .opb_value(opb_value), .chan_irq(chan_irq),
    .program_fetch_request_interrupt(program_fetch_request_interrupt), .jump_valid(jump_valid),
    .jump_target(jump_target), .chan_fn_valid(chan_fn_valid), .chan_num(chan_num), .chan_fn(chan_fn),
    .int_take(int_take), .int_vector(int_vector), .int_ret_addr(int_ret_addr), .sys_int(sys_int)
  );

  prog_model prog_model_inst (
    .pclk(pclk), .issue_valid(issue_valid), .issue_op(issue_op), .issue_d(issue_d), .issue_k(issue_k),
    .issue_p(issue_p), .carry_nz(carry_nz), .acc_value(acc_value), .opd_value(opd_value),
    .opb_value(opb_value), .chan_irq(chan_irq),
    .program_fetch_request_interrupt(program_fetch_request_interrupt)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ********************
  // Tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      close_out;
    end
  endtask

  task automatic iss(input logic [OP_W-1:0] op, input logic [8:0] d, input logic [ADDR_W-1:0] k,
                     input logic c, input logic [ADDR_W-1:0] a);
    prog_model_inst.issue(op, d, k, c, a);
    #1;
  endtask

  task automatic irq(input logic [NUM_CH-1:0] v, input logic f);
    prog_model_inst.irq(v, f);
  endtask

  task automatic sp_chk(input logic [SP_W-1:0] e);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rv[ST_SP_LSB +: SP_W]), 32'(e));
  endtask

  task automatic ie_chk(input logic [1:0] e);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rv[ST_EN_PEND:ST_IE]), 32'(e));
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_apb;
    apb(1'b0, REG_CHEN, 32'h0);
    chk(rv, CHEN_RESET);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rv, 32'h0);
    apb(1'b1, REG_CHEN, 32'h0000_00A5);
    apb(1'b0, REG_CHEN, 32'h0);
    chk(rv, 32'h0000_00A5);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk(32'(er), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rv, 32'h0);
    apb(1'b1, REG_CHEN, 32'h0);
  endtask

  task automatic t_rj;
    logic tk;
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < 2; c++) begin
        tk = (c == i % 2);
        iss(OP_RJ_LO + 7'(i), 9'h000, 16'(i * 16 + c), 1'(c), c ? 16'h0005 : 16'h0000);
        chk(32'(jump_valid), 32'(tk));
        if (tk) begin
          chk(32'(jump_target), 32'(opd_value + 16'(i * 16 + c)));
        end
      end
    end
    sp_chk(4'h4);
  endtask

  task automatic t_chan;
    for (int f = 0; f < 16; f++) begin
      iss(OP_CHD_LO + 7'(f), 9'h005, 16'h0, 1'b0, 16'h0);
      chk(32'({chan_fn_valid, chan_num, chan_fn}), 32'({1'b1, 6'h05, 4'(f)}));
      iss(OP_CHB_LO + 7'(f), 9'h000, 16'h0, 1'b0, 16'h0);
      chk(32'({chan_fn_valid, chan_num, chan_fn}), 32'({1'b1, opb_value[CH_W-1:0], 4'(f)}));
    end
  endtask

  task automatic t_mask;
    irq(32'h0000_0200, 1'b0);
    apb(1'b1, REG_CHEN, 32'h0000_0200);
    for (int j = 0; j < 2; j++) begin
      iss(OP_CHD_LO + 7'(j ? FN_SET_EN : FN_CLR_EN), 9'h009, 16'h0, 1'b0, 16'h0);
      for (int k = 0; k < 3; k++) begin
        chk(32'(sys_int), 32'(k == 2 ? j : 1 - j));
        @(posedge pclk);
        #1;
      end
    end
    irq(32'h0, 1'b0);
  endtask

  task automatic t_enable;
    logic [OP_W-1:0] hold_ops [4] = '{7'h20, 7'h23, 7'h38, 7'h5F};
    iss(OP_ENABLE, 9'h0, 16'h0, 1'b0, 16'h0);
    ie_chk(2'b10);
    foreach (hold_ops[i]) begin
      iss(hold_ops[i], 9'h0, 16'h0, 1'b0, 16'h0);
      ie_chk(2'b10);
    end
    iss(7'h01, 9'h0, 16'h0, 1'b0, 16'h0);
    ie_chk(2'b01);
    iss(OP_ENABLE, 9'h0, 16'h0, 1'b0, 16'h0);
    irq(32'h0000_0200, 1'b0);
    iss(7'h40, 9'h0, 16'h0, 1'b0, 16'h0);
    chk(32'({int_take, int_vector}), 32'({1'b1, VEC_CHAN}));
    ie_chk(2'b10);
    irq(32'h0, 1'b0);
    iss(7'h01, 9'h0, 16'h0, 1'b0, 16'h0);
    ie_chk(2'b01);
    irq(32'h0000_0200, 1'b0);
    iss(OP_DISABLE, 9'h0, 16'h0, 1'b0, 16'h0);
    chk(32'({int_take, int_ret_addr}), 32'({1'b1, issue_p + INT_SKIP_OFS}));
    irq(32'h0, 1'b0);
    iss(7'h00, 9'h0, 16'h0, 1'b0, 16'h0);
  endtask

  task automatic t_stack;
    logic [ADDR_W-1:0] rjp;
    prog_model_inst.exs(FN_SP_LOAD, 16'h000D);
    sp_chk(4'hD);
    iss(OP_ENABLE, 9'h0, 16'h0, 1'b0, 16'h0);
    iss(7'h00, 9'h0, 16'h0, 1'b0, 16'h0);
    irq(32'h0, 1'b1);
    iss(OP_RJ_LO, 9'h0, 16'h0040, 1'b0, 16'h0);
    rjp = issue_p;
    chk(32'({jump_valid, int_take}), 32'h2);
    irq(32'h0, 1'b0);
    iss(7'h00, 9'h0, 16'h0, 1'b0, 16'h0);
    chk(32'({int_take, int_vector, int_ret_addr}), 32'({1'b1, VEC_PFR, issue_p + INT_RET_OFS}));
    apb(1'b0, REG_PEND, 32'h0);
    chk(32'(rv[1:0]), 32'h3);
    sp_chk(4'hF);
    apb(1'b0, REG_STACK, 32'h0);
    chk(rv, 32'(issue_p + INT_RET_OFS));
    prog_model_inst.exs(FN_SP_LOAD, 16'h000E);
    apb(1'b0, REG_STACK, 32'h0);
    chk(rv, 32'(rjp + RJ_RET_OFS));
    prog_model_inst.exs(FN_SP_LOAD, 16'h000F);
    sp_chk(4'hF);
    iss(OP_RJ_LO, 9'h0, 16'h0050, 1'b0, 16'h0);
    sp_chk(4'h0);
    apb(1'b0, REG_STACK, 32'h0);
    chk(rv, 32'(issue_p + RJ_RET_OFS));
    prog_model_inst.exs(FN_SP_WRITE, 16'h1234);
    apb(1'b0, REG_STACK, 32'h0);
    chk(rv, 32'h0000_1234);
    apb(1'b1, REG_PEND, 32'h1);
    iss(OP_ENABLE, 9'h0, 16'h0, 1'b0, 16'h0);
    iss(7'h00, 9'h0, 16'h0, 1'b0, 16'h0);
    iss(7'h00, 9'h0, 16'h0, 1'b0, 16'h0);
    chk(32'({int_take, int_vector}), 32'({1'b1, VEC_BOUND}));
    apb(1'b1, REG_PEND, 32'h3);
    apb(1'b0, REG_PEND, 32'h0);
    chk(rv, 32'h0);
  endtask

  // ********************
  // Main
  // ********************
  initial begin
    n_fail = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_apb;
    t_rj;
    t_chan;
    t_mask;
    t_enable;
    t_stack;
    close_out;
  end
endmodule
